//--- src/ldm_ctrl.sv
// Diagnostic flags, buck gating and functional mode sequencing
`timescale 1ns/1ns
`include "ldm_defs.svh"
module ldm_ctrl
   import ldm_pkg::*;
#(
   parameter int INIT_CYCLES = `LDM_INIT_CYC
) (
   // Clock and power-on reset
   input  wire logic            REF_CLK_IN,
   input  wire logic            ARST_N_IN,
   // Reset pin from the microcontroller
   input  wire logic            RESET_PIN_N_IN,
   // Register access from the serial frame decoder
   input  wire logic            REG_WR_IN,
   input  wire logic            REG_RD_IN,
   input  wire logic [6:0]      REG_ADDR_IN,
   input  wire logic [15:0]     REG_WDATA_IN,
   input  wire logic            SPI_OK_IN,
   input  wire logic            SPI_ERR_IN,
   output logic [15:0]          REG_RDATA_OUT,
   // One-time-programmable store
   input  wire ldm_otp_t        OTP_IN,
   input  wire logic [1:0][6:0] SENSE_RANGE_SRC_IN,
   // Dimming inputs and analog detectors
   input  wire logic [1:0]      DIM_PIN_IN,
   input  wire logic [1:0]      SW_ON_IN,
   input  wire logic [1:0]      OC_DET_IN,
   input  wire logic [1:0]      SHORT_CMP_IN,
   input  wire logic [1:0]      MIN_TON_DET_IN,
   input  wire logic            TSD_CMP_IN,
   input  wire logic [7:0]      TEMP_IN,
   // Measurement sequencer
   input  wire logic            SEQ_END_IN,
   input  wire logic [3:0][7:0] VLED_RAW_IN,
   output logic [3:0][8:0]      VLED_OUT,
   output logic [1:0]           FORCE_MEAS_OUT,
   // Buck control
   output ldm_ctrl_t            CTRL_OUT,
   output ldm_cfg_t             CFG1_OUT,
   output ldm_cfg_t             CFG2_OUT,
   output logic [1:0][6:0]      TRIM_OUT,
   output logic [1:0]           BUCK_RUN_OUT,
   output logic [1:0]           FIXED_TOFF_OUT,
   output ldm_mode_t            MODE_OUT
);

   ldm_state_t s;
   ldm_state_t next_s;

   // -----------------------------------------------------------------
   // Combinational next state
   // -----------------------------------------------------------------

   logic       wr_blk;
   logic       wr_ok;
   logic       clr_ok;
   logic       rd13;
   logic       rd14;
   logic       rst_fall;
   logic       rst_rise;
   logic       tsd_end;
   logic       pins_ignored;
   logic [1:0] en_eff;
   logic [1:0] drive;
   logic [2:0] otp_md;

   // Write gating follows the latched mode, not the live field
   always_comb begin
      otp_md   = OTP_IN.ctrl.failsafe_mode_select;
      wr_blk   = ((s.mode == LDM_FSO) && ((s.mode_latch == `LDM_MODE_FS2) ||
                  (s.mode_latch == `LDM_MODE_FS4))) ||
                 ((s.mode == LDM_SA) && (s.mode_latch == `LDM_MODE_SA6));
      wr_ok    = REG_WR_IN && !wr_blk;
      clr_ok   = !wr_blk;
      rd13     = REG_RD_IN && (REG_ADDR_IN == `LDM_OFS_LED_FLT) && clr_ok;
      rd14     = REG_RD_IN && (REG_ADDR_IN == `LDM_OFS_CHIP_FLT) && clr_ok;
      rst_fall = s.rst_q && !RESET_PIN_N_IN;
      rst_rise = !s.rst_q && RESET_PIN_N_IN;
      tsd_end  = s.tsd_act && !TSD_CMP_IN && (TEMP_IN < s.thr);
      pins_ignored = (s.mode == LDM_FSO) || (s.mode == LDM_SA);
   end

   always_comb begin
      next_s = s;
      next_s.force_meas = 2'h0;
      next_s.rst_q = RESET_PIN_N_IN;

      // Register writes; OTP loads further down override them
      if (wr_ok) begin
         unique case (REG_ADDR_IN)
            `LDM_OFS_CTRL: next_s.ctrl = ldm_ctrl_t'(REG_WDATA_IN);
            `LDM_OFS_CFG1: next_s.cfg1 = ldm_cfg_t'(REG_WDATA_IN);
            `LDM_OFS_CFG2: next_s.cfg2 = ldm_cfg_t'(REG_WDATA_IN);
            `LDM_OFS_THR:  next_s.thr  = REG_WDATA_IN[7:0];
            `LDM_OFS_FDUR: next_s.fdur = REG_WDATA_IN[8:0];
            default: ;
         endcase
      end

      // In fail-safe modes 4 and 5, buck enables stay low after init until the first valid serial operation
      if (SPI_OK_IN) begin
         next_s.en_hold = 1'b0;
      end

      // Chip-level flags: a new event beats the read that clears it
      next_s.tw_f   = (TEMP_IN >= s.thr) || (s.tw_f && !rd14);
      next_s.tsd_f  = TSD_CMP_IN || (s.tsd_f && !rd14);
      next_s.serr_f = SPI_ERR_IN || (s.serr_f && !rd14);
      next_s.hwr_f  = s.hwr_f && !rd14;
      next_s.fso_f  = s.fso_f && !rd14;
      if (TSD_CMP_IN) begin
         next_s.tsd_act = 1'b1;
      end else if (tsd_end) begin
         next_s.tsd_act = 1'b0;
      end

      // Per-channel diagnostics and gating
      for (int i = 0; i < 2; i++) begin
         // Debounce: a level must hold for the full window to pass
         if (DIM_PIN_IN[i] != s.deb[i]) begin
            if (s.deb_cnt[i] == 4'(`LDM_DEB_CYC - 1)) begin
               next_s.deb[i] = DIM_PIN_IN[i];
               next_s.deb_cnt[i] = 4'h0;
            end else begin
               next_s.deb_cnt[i] = s.deb_cnt[i] + 4'h1;
            end
         end else begin
            next_s.deb_cnt[i] = 4'h0;
         end

         // Forced measurement after programmed sequences without an edge
         if (next_s.deb[i] != s.deb[i]) begin
            next_s.seq_cnt[i] = 9'h000;
         end else if (SEQ_END_IN && (s.fdur != 9'h000)) begin
            if ((s.seq_cnt[i] + 9'h001) >= s.fdur) begin
               next_s.force_meas[i] = 1'b1;
               next_s.seq_cnt[i] = 9'h000;
            end else begin
               next_s.seq_cnt[i] = s.seq_cnt[i] + 9'h001;
            end
         end

         // Thermal shutdown block and its release
         en_eff[i] = s.ctrl.buck_en[i] && !s.en_hold;
         next_s.en_q[i] = en_eff[i];
         if (TSD_CMP_IN) begin
            next_s.tsd_blk[i] = 1'b1;
         end else if (tsd_end && s.ctrl.auto_recover[i]) begin
            next_s.tsd_blk[i] = 1'b0;
         end else if (!s.tsd_act && en_eff[i] && !s.en_q[i]) begin
            next_s.tsd_blk[i] = 1'b0;
         end

         // Overcurrent lock held until the flag is read
         next_s.oc_f[i]    = OC_DET_IN[i] || (s.oc_f[i] && !rd13);
         next_s.oc_lock[i] = OC_DET_IN[i] || (s.oc_lock[i] && !rd13);
         next_s.mint_f[i]  = MIN_TON_DET_IN[i] || (s.mint_f[i] && !rd13);

         // Output drive; pins have no say in fail-safe or stand-alone
         drive[i] = en_eff[i] && !s.tsd_blk[i] && !s.tsd_act && !s.oc_lock[i] &&
                    (pins_ignored || s.deb[i]) &&
                    ((s.mode == LDM_NORMAL) || pins_ignored);
         next_s.run[i] = drive[i] && !OC_DET_IN[i] && !TSD_CMP_IN;
         next_s.fix_toff[i] = SHORT_CMP_IN[i] && s.run[i];

         // On-time: count while the switch is on, capture at its end
         next_s.sw_q[i] = SW_ON_IN[i] && s.run[i];
         if (SW_ON_IN[i] && s.run[i]) begin
            if (s.ton_cnt[i] < 12'(`LDM_OPEN_CYC)) begin
               next_s.ton_cnt[i] = s.ton_cnt[i] + 12'h001;
            end
         end else if (s.sw_q[i]) begin
            next_s.ton[i] = 8'(s.ton_cnt[i] / 12'(`LDM_TON_STEP_CYC));
            next_s.ton_cnt[i] = 12'h000;
         end
         // Overflow flags an open string but never stops the buck
         next_s.open_f[i] = (s.ton_cnt[i] == 12'(`LDM_OPEN_CYC - 1)) ||
                            (s.open_f[i] && !rd13);
      end

      // Functional mode sequencing
      unique case (s.mode)
         LDM_RESET: begin
            next_s = '0;
            next_s.thr   = `LDM_THR_RST;
            next_s.hwr_f = s.hwr_f;
            next_s.rst_q = RESET_PIN_N_IN;
            next_s.mode  = LDM_INIT;
         end
         LDM_INIT: begin
            next_s.init_cnt = s.init_cnt + 16'h0001;
            if (s.init_cnt == 16'(INIT_CYCLES - 1)) begin
               next_s.mode = LDM_NORMAL;
               if (OTP_IN.lock) begin
                  next_s.ctrl.failsafe_mode_select = otp_md;
                  if (otp_md[2:1] == 2'h3) begin
                     next_s.mode = LDM_SA;
                  end
                  if ((otp_md == `LDM_MODE_OTP) || (otp_md[2] == 1'b1)) begin
                     next_s.ctrl = OTP_IN.ctrl;
                     next_s.cfg1 = OTP_IN.cfg1;
                     next_s.cfg2 = OTP_IN.cfg2;
                  end
                  if ((otp_md == `LDM_MODE_FS4) || (otp_md == `LDM_MODE_FS5)) begin
                     next_s.en_hold = 1'b1;
                  end
                  if (otp_md[2:1] == 2'h3) begin
                     next_s.trim = SENSE_RANGE_SRC_IN;
                     next_s.mode_latch = otp_md;
                     next_s.fso_f = 1'b1;
                  end
               end
            end
         end
         LDM_NORMAL: begin
            if (rst_fall) begin
               if (OTP_IN.lock && (s.ctrl.failsafe_mode_select >= `LDM_MODE_FS2) &&
                   (s.ctrl.failsafe_mode_select < `LDM_MODE_SA6)) begin
                  next_s.mode = LDM_FSO;
                  next_s.ctrl = OTP_IN.ctrl;
                  next_s.cfg1 = OTP_IN.cfg1;
                  next_s.cfg2 = OTP_IN.cfg2;
                  next_s.trim = SENSE_RANGE_SRC_IN;
                  next_s.mode_latch = otp_md;
                  next_s.fso_f = 1'b1;
                  next_s.en_hold = 1'b0;
               end else begin
                  next_s.mode = LDM_RESET;
               end
            end
         end
         LDM_FSO: begin
            // Reset pin only exits here; it never resets the device
            if (rst_rise) begin
               next_s.mode = LDM_NORMAL;
               next_s.mode_latch = 3'h0;
            end else if (wr_ok && (REG_ADDR_IN == `LDM_OFS_CTRL) &&
                         ((s.mode_latch == `LDM_MODE_FS3) ||
                          (s.mode_latch == `LDM_MODE_FS5)) &&
                         (REG_WDATA_IN[10:9] == 2'h0)) begin
               next_s.mode = LDM_NORMAL;
               next_s.mode_latch = 3'h0;
            end
         end
         LDM_SA: begin
            if (rst_fall) begin
               next_s.mode = LDM_RESET;
            end
         end
         default: begin
            next_s.mode = LDM_RESET;
         end
      endcase

      // Results with odd parity; after the mode case so a soft reset never leaves bad parity
      for (int k = 0; k < 4; k++) begin
         next_s.vled[k] = {~^VLED_RAW_IN[k], VLED_RAW_IN[k]};
      end

      // Read mux, registered for the frame encoder
      next_s.rdata = 16'h0000;
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            `LDM_OFS_CTRL:  next_s.rdata = 16'(s.ctrl);
            `LDM_OFS_CFG1:  next_s.rdata = 16'(s.cfg1);
            `LDM_OFS_CFG2:  next_s.rdata = 16'(s.cfg2);
            `LDM_OFS_THR:   next_s.rdata = {8'h00, s.thr};
            `LDM_OFS_FDUR:  next_s.rdata = {7'h00, s.fdur};
            `LDM_OFS_LED_FLT: begin
               next_s.rdata[`LDM_LF_OPEN +: 2]  = s.open_f;
               next_s.rdata[`LDM_LF_SHORT +: 2] = SHORT_CMP_IN;
               next_s.rdata[`LDM_LF_OC +: 2]    = s.oc_f;
               next_s.rdata[`LDM_LF_MINT +: 2]  = s.mint_f;
               next_s.rdata[`LDM_LF_RUN +: 2]   = s.run;
               next_s.rdata[`LDM_LF_PIN +: 2]   = s.deb;
            end
            `LDM_OFS_CHIP_FLT: begin
               next_s.rdata[`LDM_CF_TW]   = s.tw_f;
               next_s.rdata[`LDM_CF_TSD]  = s.tsd_f;
               next_s.rdata[`LDM_CF_SERR] = s.serr_f;
               next_s.rdata[`LDM_CF_HWR]  = s.hwr_f;
               next_s.rdata[`LDM_CF_FSO]  = s.fso_f;
            end
            `LDM_OFS_TON:   next_s.rdata = {s.ton[1], s.ton[0]};
            default:        next_s.rdata = 16'h0000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------

   // Power-on reset: only constants, hardware reset flag comes up set
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         s       <= '0;
         s.thr   <= `LDM_THR_RST;
         s.hwr_f <= 1'b1;
         s.mode  <= LDM_RESET;
      end else begin
         s <= next_s;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------

   // All outputs come straight from the state register
   assign REG_RDATA_OUT  = s.rdata;
   assign VLED_OUT       = s.vled;
   assign FORCE_MEAS_OUT = s.force_meas;
   assign CTRL_OUT       = s.ctrl;
   assign CFG1_OUT       = s.cfg1;
   assign CFG2_OUT       = s.cfg2;
   assign TRIM_OUT       = s.trim;
   assign BUCK_RUN_OUT   = s.run;
   assign FIXED_TOFF_OUT = s.fix_toff;
   assign MODE_OUT       = s.mode;

endmodule : ldm_ctrl

//--- src/ldm_defs.svh
// Constants for the LED driver diagnostic flags and functional mode controller
`ifndef LDM_DEFS_SVH
`define LDM_DEFS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define LDM_OFS_CTRL      7'h01
`define LDM_OFS_CFG1      7'h02
`define LDM_OFS_CFG2      7'h03
`define LDM_OFS_THR       7'h04
`define LDM_OFS_FDUR      7'h05
`define LDM_OFS_LED_FLT   7'h13
`define LDM_OFS_CHIP_FLT  7'h14
`define LDM_OFS_TON       7'h15

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define LDM_LF_OPEN       0
`define LDM_LF_SHORT      2
`define LDM_LF_OC         4
`define LDM_LF_MINT       6
`define LDM_LF_RUN        8
`define LDM_LF_PIN        10
`define LDM_CF_TW         0
`define LDM_CF_TSD        1
`define LDM_CF_SERR       2
`define LDM_CF_HWR        3
`define LDM_CF_FSO        4
`define LDM_THR_RST       8'hB3
`define LDM_MODE_OFF      3'h0
`define LDM_MODE_OTP      3'h1
`define LDM_MODE_FS2      3'h2
`define LDM_MODE_FS3      3'h3
`define LDM_MODE_FS4      3'h4
`define LDM_MODE_FS5      3'h5
`define LDM_MODE_SA6      3'h6

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define LDM_CLK_NS        20
`define LDM_DEB_NS        200
`define LDM_TON_STEP_NS   200
`define LDM_OPEN_NS       50000
`define LDM_INIT_NS       150000
`define LDM_DEB_CYC       ((`LDM_DEB_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS)
`define LDM_TON_STEP_CYC  (`LDM_TON_STEP_NS / `LDM_CLK_NS)
`define LDM_OPEN_CYC      (`LDM_OPEN_NS / `LDM_CLK_NS)
`define LDM_INIT_CYC      (`LDM_INIT_NS / `LDM_CLK_NS)

`endif

//--- src/ldm_pkg.sv
// Types shared by the LED driver diagnostic and mode controller
package ldm_pkg;

   // Functional modes
   typedef enum logic [2:0] {
      LDM_RESET  = 3'h0,
      LDM_INIT   = 3'h1,
      LDM_NORMAL = 3'h2,
      LDM_FSO    = 3'h3,
      LDM_SA     = 3'h4
   } ldm_mode_t;

   // Control word, also the layout of the control register
   typedef struct packed {
      logic       pad;
      logic [1:0] oc_limit2;
      logic [1:0] oc_limit1;
      logic [2:0] failsafe_mode_select;
      logic [1:0] range2;
      logic [1:0] range1;
      logic [1:0] auto_recover;
      logic [1:0] buck_en;
   } ldm_ctrl_t;

   // Per-channel buck settings, also a register layout
   typedef struct packed {
      logic       pad;
      logic [4:0] off_time_code;
      logic [1:0] sense_range_code;
      logic [7:0] peak_threshold_code;
   } ldm_cfg_t;

   // Content of the one-time-programmable store
   typedef struct packed {
      logic      lock;
      ldm_ctrl_t ctrl;
      ldm_cfg_t  cfg1;
      ldm_cfg_t  cfg2;
   } ldm_otp_t;

   // Whole state of the controller
   typedef struct packed {
      ldm_mode_t       mode;
      logic [15:0]     init_cnt;
      ldm_ctrl_t       ctrl;
      ldm_cfg_t        cfg1;
      ldm_cfg_t        cfg2;
      logic [7:0]      thr;
      logic [8:0]      fdur;
      logic [1:0][6:0] trim;
      logic [2:0]      mode_latch;
      logic            en_hold;
      logic [1:0]      open_f;
      logic [1:0]      oc_f;
      logic [1:0]      mint_f;
      logic            tw_f;
      logic            tsd_f;
      logic            serr_f;
      logic            hwr_f;
      logic            fso_f;
      logic            tsd_act;
      logic [1:0]      tsd_blk;
      logic [1:0]      oc_lock;
      logic [1:0]      en_q;
      logic            rst_q;
      logic [1:0]      deb;
      logic [1:0][3:0] deb_cnt;
      logic [1:0][8:0] seq_cnt;
      logic [1:0]      sw_q;
      logic [1:0][11:0] ton_cnt;
      logic [1:0][7:0] ton;
      logic [1:0]      run;
      logic [1:0]      fix_toff;
      logic [1:0]      force_meas;
      logic [3:0][8:0] vled;
      logic [15:0]     rdata;
   } ldm_state_t;

endpackage : ldm_pkg

//--- verif/ldm_ctrl_sva.sv
// Port-level checks for the diagnostic flag and mode controller
`timescale 1ns/1ns
module ldm_ctrl_sva
   import ldm_pkg::*;
#(
   parameter int INIT_CYCLES = 20
) (
   // Clock and power-on reset
   input  wire logic            REF_CLK_IN,
   input  wire logic            ARST_N_IN,
   // Watched ports
   input  wire logic            REG_RD_IN,
   input  wire logic [15:0]     REG_RDATA_OUT,
   input  wire logic [1:0]      OC_DET_IN,
   input  wire logic            TSD_CMP_IN,
   input  wire logic [1:0]      SHORT_CMP_IN,
   input  wire logic [3:0][7:0] VLED_RAW_IN,
   input  wire logic [3:0][8:0] VLED_OUT,
   input  wire logic [1:0]      FORCE_MEAS_OUT,
   input  wire logic [1:0]      BUCK_RUN_OUT,
   input  wire logic [1:0]      FIXED_TOFF_OUT,
   input  wire ldm_mode_t       MODE_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   logic [15:0] init_len;
   // Length of the current init stretch, a counter since the wait is too long to unroll
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         init_len <= 16'h0000;
      end else begin
         init_len <= (MODE_OUT == LDM_INIT) ? init_len + 16'h0001 : 16'h0000;
      end
   end
   // Read data only follows a read strobe
   a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 16'h0000)
      else $error("read data not zero without a read");
   a_oc_stops_buck: assert property ((OC_DET_IN != 2'b00) |=>
      (BUCK_RUN_OUT & $past(OC_DET_IN)) == 2'b00) else $error("buck runs after overcurrent");
   a_tsd_stops_all: assert property (TSD_CMP_IN |=> BUCK_RUN_OUT == 2'b00)
      else $error("buck runs during shutdown");
   a_toff_fixed: assert property (FIXED_TOFF_OUT == ($past(SHORT_CMP_IN) & $past(BUCK_RUN_OUT)))
      else $error("fixed off-time wrong");
   a_vled_odd_parity: assert property ($past(ARST_N_IN) |->
      VLED_OUT[0] == {~^$past(VLED_RAW_IN[0]), $past(VLED_RAW_IN[0])}) else $error("bad parity");
   a_reset_to_init: assert property (MODE_OUT == LDM_RESET |=> MODE_OUT == LDM_INIT)
      else $error("reset not followed by init");
   a_init_length: assert property (($past(MODE_OUT) == LDM_INIT && MODE_OUT != LDM_INIT &&
      MODE_OUT != LDM_RESET) |-> init_len >= INIT_CYCLES - 1 && init_len <= INIT_CYCLES + 1)
      else $error("init length wrong");
   a_force_one_pulse: assert property (FORCE_MEAS_OUT[0] |=> !FORCE_MEAS_OUT[0])
      else $error("forced measurement pulse too long");
   // Main scenarios reached
   c_force: cover property (FORCE_MEAS_OUT[0]);
   c_failsafe: cover property (MODE_OUT == LDM_FSO);
   c_tsd: cover property (TSD_CMP_IN ##1 BUCK_RUN_OUT == 2'b00);
endmodule : ldm_ctrl_sva

bind ldm_ctrl ldm_ctrl_sva #(.INIT_CYCLES(INIT_CYCLES)) u_sva (
   .REF_CLK_IN, .ARST_N_IN, .REG_RD_IN, .REG_RDATA_OUT, .OC_DET_IN, .TSD_CMP_IN,
   .SHORT_CMP_IN, .VLED_RAW_IN, .VLED_OUT, .FORCE_MEAS_OUT, .BUCK_RUN_OUT, .FIXED_TOFF_OUT,
   .MODE_OUT);

//--- verif/ldm_ctrl_tb.sv
// Self-checking bench for the diagnostic flag and mode controller
`timescale 1ns/1ns
`include "ldm_defs.svh"
module ldm_ctrl_tb;
   import ldm_pkg::*;
   logic             clk, arst_n, wr, rd, ok, err, pin_n, thermal_shutdown_flag, seq;
   logic [6:0]       addr;
   logic [15:0]      wdata, rdata, q;
   logic [1:0]       dim, oc, shrt, fm, run, toff, sw, mint;
   logic [1:0][6:0]  srng, trim;
   logic [7:0]       temp;
   logic [3:0][7:0]  raw;
   logic [3:0][8:0]  vled;
   ldm_otp_t         otp;
   ldm_ctrl_t        ctrl;
   ldm_mode_t        mode;
   int               fails, tests_run, cyc;
   ldm_ctrl #(.INIT_CYCLES(20)) u_dut (.REF_CLK_IN(clk), .ARST_N_IN(arst_n),
      .RESET_PIN_N_IN(pin_n), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .SPI_OK_IN(ok), .SPI_ERR_IN(err), .REG_RDATA_OUT(rdata),
      .OTP_IN(otp), .SENSE_RANGE_SRC_IN(srng), .DIM_PIN_IN(dim), .SW_ON_IN(sw),
      .OC_DET_IN(oc), .SHORT_CMP_IN(shrt), .MIN_TON_DET_IN(mint), .TSD_CMP_IN(thermal_shutdown_flag),
      .TEMP_IN(temp), .SEQ_END_IN(seq), .VLED_RAW_IN(raw), .VLED_OUT(vled),
      .FORCE_MEAS_OUT(fm), .CTRL_OUT(ctrl), .CFG1_OUT(), .CFG2_OUT(), .TRIM_OUT(trim),
      .BUCK_RUN_OUT(run), .FIXED_TOFF_OUT(toff), .MODE_OUT(mode));
   ldm_mcu_model u_mcu (.clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
      .addr_out(addr), .wdata_out(wdata), .ok_out(ok), .err_out(err), .pin_n_out(pin_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Sequencer ticks every fourth cycle; raw codes keep moving; hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      #1;
      seq = (cyc % 4) == 0;
      raw = raw + 32'h1357_9BDF;
      if (cyc == 20000) begin
         fails = fails + 1;
         final_report();
      end
   end
   // ----------------------------------------
   // Shared checking tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run = tests_run + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic rdchk(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
      u_mcu.acc(1'b0, a, 16'h0000, q);
      chk(q & m, e);
   endtask : rdchk
   task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
      u_mcu.acc(1'b1, a, d, q);
   endtask : wr_reg
   // Bounded waits; the rule gives no exact latency here
   task automatic wait_run(input logic [1:0] e);
      for (int i = 0; i < 60 && run !== e; i++) @(posedge clk) #1;
      chk({14'h0000, run}, {14'h0000, e});
   endtask : wait_run
   task automatic wait_mode(input ldm_mode_t e);
      for (int i = 0; i < 60 && mode !== e; i++) @(posedge clk) #1;
      chk(16'(mode), 16'(e));
   endtask : wait_mode
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_boot();
      wait_mode(LDM_NORMAL);
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0008, 16'h0008);
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0008, 16'h0000);
      rdchk(`LDM_OFS_THR, 16'h00FF, 16'h00B3);
      $display("boot test done");
   endtask : t_boot
   task automatic t_thermal();
      wr_reg(`LDM_OFS_FDUR, 16'h0002);
      wr_reg(`LDM_OFS_CTRL, 16'h0307);
      wait_run(2'b11);
      for (int i = 0; i < 20 && fm[0] !== 1'b1; i++) @(posedge clk) #1;
      chk({15'h0000, fm[0]}, 16'h0001);
      temp = 8'hB3;
      repeat (2) @(posedge clk) #1;
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0001, 16'h0001);
      temp = 8'hB2;
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0001, 16'h0001);
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0001, 16'h0000);
      thermal_shutdown_flag = 1'b1;
      wait_run(2'b00);
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0002, 16'h0002);
      thermal_shutdown_flag = 1'b0;
      wait_run(2'b01);
      wr_reg(`LDM_OFS_CTRL, 16'h0305);
      wr_reg(`LDM_OFS_CTRL, 16'h0307);
      wait_run(2'b11);
      $display("thermal test done");
   endtask : t_thermal
   task automatic t_diag();
      oc = 2'b01;
      @(posedge clk) #1;
      oc = 2'b00;
      repeat (8) @(posedge clk) #1;
      chk({14'h0000, run}, 16'h0002);
      shrt = 2'b10;
      rdchk(`LDM_OFS_LED_FLT, 16'h003C, 16'h0018);
      shrt = 2'b00;
      wait_run(2'b11);
      u_mcu.err_pulse();
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0004, 16'h0004);
      $display("diagnostic test done");
   endtask : t_diag
   task automatic t_ontime();
      sw = 2'b01;
      repeat (25) @(posedge clk) #1;
      sw = 2'b10;
      rdchk(`LDM_OFS_TON, 16'h00FF, 16'h0002);
      repeat (2505) @(posedge clk) #1;
      sw = 2'b00;
      chk({14'h0000, run}, 16'h0003);
      rdchk(`LDM_OFS_LED_FLT, 16'h0003, 16'h0002);
      rdchk(`LDM_OFS_TON, 16'hFF00, 16'hFA00);
      mint = 2'b01;
      @(posedge clk) #1;
      mint = 2'b00;
      rdchk(`LDM_OFS_LED_FLT, 16'h00C0, 16'h0040);
      rdchk(`LDM_OFS_LED_FLT, 16'h00C0, 16'h0000);
      $display("on-time test done");
   endtask : t_ontime
   task automatic t_fso();
      dim = 2'b00;
      wait_run(2'b00);
      u_mcu.pin(1'b0);
      wait_mode(LDM_FSO);
      chk(16'(ctrl), 16'h0303);
      chk(16'(trim), 16'h1A55);
      wait_run(2'b11);
      rdchk(`LDM_OFS_CHIP_FLT, 16'h0010, 16'h0010);
      wr_reg(`LDM_OFS_CTRL, 16'h0003);
      wait_mode(LDM_NORMAL);
      u_mcu.pin(1'b1);
      $display("fail-safe test done");
   endtask : t_fso
   task automatic final_report();
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   // Main sequence
   initial begin
      {arst_n, oc, shrt, sw, mint, thermal_shutdown_flag, seq, fails, tests_run, cyc} = '0;
      {dim, temp, raw} = {2'b11, 8'h40, 32'h0000_0000};
      otp = {1'b1, 16'h0303, 32'h0000_0000};
      srng = 14'h1A55;
      repeat (10) @(posedge clk);
      #1 arst_n = 1'b1;
      t_boot();
      t_thermal();
      t_diag();
      t_ontime();
      t_fso();
      final_report();
   end
endmodule : ldm_ctrl_tb

//--- verif/ldm_mcu_model.sv
// Microcontroller model: register accesses, invalid frames and the reset pin
`timescale 1ns/1ns
module ldm_mcu_model (
   // Clock and answer
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   // Register access, frame status and reset pin
   output logic             wr_out,
   output logic             rd_out,
   output logic [6:0]       addr_out,
   output logic [15:0]      wdata_out,
   output logic             ok_out,
   output logic             err_out,
   output logic             pin_n_out
);
   // Idle bus at time zero
   initial begin
      {wr_out, rd_out, ok_out, err_out} = 4'h0;
      addr_out = 7'h7F;
      wdata_out = 16'hFFFF;
      pin_n_out = 1'b1;
   end
   // One access; a read of the LED fault word is what releases an overcurrent lock
   task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      @(posedge clk_in) #1;
      {wr_out, rd_out, ok_out} = {w, !w, 1'b1};
      addr_out = a;
      wdata_out = d;
      @(posedge clk_in) #1;
      {wr_out, rd_out, ok_out} = 3'h0;
      addr_out = ~a;
      wdata_out = ~d;
      q = rdata_in;
   endtask : acc
   // Broken frame reported by the frame decoder
   task automatic err_pulse();
      @(posedge clk_in) #1;
      err_out = 1'b1;
      @(posedge clk_in) #1;
      err_out = 1'b0;
   endtask : err_pulse
   // Reset pin level, edges enter or leave fail-safe
   task automatic pin(input logic v);
      @(posedge clk_in) #1;
      pin_n_out = v;
   endtask : pin
endmodule : ldm_mcu_model
